// ==== hw/hspll_pkg.sv ====
// package for the line-locked pixel clock control block
// assumes one system clock domain and a decoded serial register port
package hspll_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] HSPLL_OFS_DIV_UPPER = 8'h01; // divisor bits 11:4
  localparam logic [7:0] HSPLL_OFS_DIV_LOWER = 8'h02; // divisor bits 3:0 in data 7:4
  localparam logic [7:0] HSPLL_OFS_REGION    = 8'h03;
  localparam logic [7:0] HSPLL_OFS_PUMP      = 8'h04;
  localparam logic [7:0] HSPLL_OFS_PHASE     = 8'h05;
  localparam logic [7:0] HSPLL_OFS_POLARITY  = 8'h06;

  // ==========================================================
  // field positions
  localparam int HSPLL_LOWER_POS = 4;  // low divisor nibble inside its register
  localparam int HSPLL_HPOL_POS  = 0;  // sync polarity bit
  localparam int HSPLL_CPOL_POS  = 1;  // freewheel_hold_in polarity bit
  localparam int HSPLL_PHASE_SH  = 11; // phase code to accumulator threshold

  // ==========================================================
  // reset values
  localparam logic [11:0] HSPLL_DIV_RST    = 12'h35F;
  localparam logic [1:0]  HSPLL_REGION_RST = 2'h0;
  localparam logic [2:0]  HSPLL_PUMP_RST   = 3'h2;
  localparam logic [4:0]  HSPLL_PHASE_RST  = 5'h00;
  localparam logic [15:0] HSPLL_STEP_RST   = 16'h2000;
  localparam logic [15:0] HSPLL_STEP_MIN   = 16'h0001;

  // ==========================================================
  // oscillator region lower bounds in MHz
  localparam logic [7:0] HSPLL_REG0_MHZ = 8'h0A; // 10 to 45
  localparam logic [7:0] HSPLL_REG1_MHZ = 8'h2D; // 45 to 90
  localparam logic [7:0] HSPLL_REG2_MHZ = 8'h5A; // 90 to 150
  localparam logic [7:0] HSPLL_REG3_MHZ = 8'h96; // 150 and above

  // ==========================================================
  // pump currents in microamps
  localparam logic [10:0] HSPLL_IP0 = 11'h032; // 50
  localparam logic [10:0] HSPLL_IP1 = 11'h064; // 100
  localparam logic [10:0] HSPLL_IP2 = 11'h096; // 150
  localparam logic [10:0] HSPLL_IP3 = 11'h0FA; // 250
  localparam logic [10:0] HSPLL_IP4 = 11'h15E; // 350
  localparam logic [10:0] HSPLL_IP5 = 11'h1F4; // 500
  localparam logic [10:0] HSPLL_IP6 = 11'h2EE; // 750
  localparam logic [10:0] HSPLL_IP7 = 11'h5DC; // 1500

  // ==========================================================
  // configuration carrier
  typedef struct packed {
    logic [1:0] osc_region_code;
    logic [2:0] pump_code;
    logic [4:0] phase_code;
    logic       freewheel_hold_in_pol;
    logic       sync_pol;
  } hspll_cfg_t;

endpackage

// ==== hw/hspll_top.sv ====
// line-locked pixel clock control: registers, divider, phase loop, phase shift
// assumes register port strobes are already decoded on CLK_SYS by the serial port
module hspll_top
  import hspll_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        RESETN,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_WE,
  output logic      [7:0]  REG_RDATA,
  input  wire logic        HSYNC_IN,
  input  wire logic        FREEWHEEL_HOLD_IN,
  input  wire logic        EXT_CLK_SEL,
  input  wire logic        EXT_PIX_IN,
  output logic             PIX_TICK,
  output logic             SAMPLE_TICK,
  output logic             DIV_TICK,
  output logic             ALIGNED_LINE_SYNC_OUT,
  output logic      [1:0]  OSC_REGION_CODE,
  output logic      [7:0]  OSC_REGION_MIN_MHZ,
  output logic      [10:0] PUMP_UA,
  output logic      [15:0] OSC_STEP
);

  // ==========================================================
  // input synchronisers
  logic [3:0] meta_r;
  logic [3:0] sync_r;
  logic       ext_d_r;

  // two flops per async pin, second stage only read by logic
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      meta_r  <= 4'h0;
      sync_r  <= 4'h0;
      ext_d_r <= 1'b0;
    end else begin
      meta_r  <= {EXT_PIX_IN, EXT_CLK_SEL, FREEWHEEL_HOLD_IN, HSYNC_IN};
      sync_r  <= meta_r;
      ext_d_r <= sync_r[3];
    end
  end

  // ==========================================================
  // register file
  logic [7:0]  div_upper_r, div_upper_nxt;
  logic [7:0]  div_lower_r, div_lower_nxt;
  logic [11:0] div_r, div_nxt;
  hspll_cfg_t  cfg_r, cfg_nxt;
  logic [7:0]  rdata_r, rdata_nxt;

  // write decode and divisor staging
  always_comb begin
    div_upper_nxt = div_upper_r;
    div_lower_nxt = div_lower_r;
    div_nxt       = div_r;
    cfg_nxt       = cfg_r;
    if (REG_WE) begin
      unique case (REG_ADDR)
        HSPLL_OFS_DIV_UPPER: div_upper_nxt = REG_WDATA;         // staged only
        HSPLL_OFS_DIV_LOWER: begin
          div_lower_nxt = REG_WDATA;
          div_nxt = {div_upper_r, REG_WDATA[HSPLL_LOWER_POS +: 4]};
        end
        HSPLL_OFS_REGION:    cfg_nxt.osc_region_code = REG_WDATA[1:0];
        HSPLL_OFS_PUMP:      cfg_nxt.pump_code = REG_WDATA[2:0];
        HSPLL_OFS_PHASE:     cfg_nxt.phase_code = REG_WDATA[4:0];
        HSPLL_OFS_POLARITY: begin
          cfg_nxt.sync_pol  = REG_WDATA[HSPLL_HPOL_POS];
          cfg_nxt.freewheel_hold_in_pol = REG_WDATA[HSPLL_CPOL_POS];
        end
        default: ;
      endcase
    end
  end

  // read mux, unmapped reads zero
  always_comb begin
    unique case (REG_ADDR)
      HSPLL_OFS_DIV_UPPER: rdata_nxt = div_upper_r;
      HSPLL_OFS_DIV_LOWER: rdata_nxt = div_lower_r;
      HSPLL_OFS_REGION:    rdata_nxt = {6'h00, cfg_r.osc_region_code};
      HSPLL_OFS_PUMP:      rdata_nxt = {5'h00, cfg_r.pump_code};
      HSPLL_OFS_PHASE:     rdata_nxt = {3'h0, cfg_r.phase_code};
      HSPLL_OFS_POLARITY:  rdata_nxt = {6'h00, cfg_r.freewheel_hold_in_pol, cfg_r.sync_pol};
      default:             rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      div_upper_r <= HSPLL_DIV_RST[11:4];
      div_lower_r <= {HSPLL_DIV_RST[3:0], 4'h0};
      div_r       <= HSPLL_DIV_RST;
      cfg_r       <= '{HSPLL_REGION_RST, HSPLL_PUMP_RST, HSPLL_PHASE_RST, 1'b0, 1'b0};
      rdata_r     <= 8'h00;
    end else begin
      div_upper_r <= div_upper_nxt;
      div_lower_r <= div_lower_nxt;
      div_r       <= div_nxt;
      cfg_r       <= cfg_nxt;
      rdata_r     <= rdata_nxt;
    end
  end

  // ==========================================================
  // decodes of region and pump code
  logic [10:0] pump_ua;
  logic [7:0]  region_mhz;

  always_comb begin
    unique case (cfg_r.pump_code)
      3'h0: pump_ua = HSPLL_IP0;
      3'h1: pump_ua = HSPLL_IP1;
      3'h2: pump_ua = HSPLL_IP2;
      3'h3: pump_ua = HSPLL_IP3;
      3'h4: pump_ua = HSPLL_IP4;
      3'h5: pump_ua = HSPLL_IP5;
      3'h6: pump_ua = HSPLL_IP6;
      3'h7: pump_ua = HSPLL_IP7;
    endcase
    unique case (cfg_r.osc_region_code)
      2'h0: region_mhz = HSPLL_REG0_MHZ;
      2'h1: region_mhz = HSPLL_REG1_MHZ;
      2'h2: region_mhz = HSPLL_REG2_MHZ;
      2'h3: region_mhz = HSPLL_REG3_MHZ;
    endcase
  end

  // ==========================================================
  // oscillator, divider, phase detector
  logic        hs_act, hs_act_d_r, hs_rise, freewheel_hold_in_act, ext_sel, ext_rise;
  logic [15:0] acc_r, acc_nxt, step_r, step_nxt, thr, d_old;
  logic [16:0] sum_pix, sum_smp;
  logic [11:0] cnt_r, cnt_nxt;
  logic        pix, smp, div_tick, hso_r, hso_nxt;
  logic        pix_r, smp_r, div_r_tick;
  logic [7:0]  ecyc_r, ecyc_nxt, eper_r, eper_nxt;
  logic [13:0] ext_at, ext_nx, ext_goal;

  assign hs_act    = sync_r[0] ^ ~cfg_r.sync_pol;   // pol 0 means active low
  assign freewheel_hold_in_act = sync_r[1] ^ ~cfg_r.freewheel_hold_in_pol;
  assign ext_sel   = sync_r[2];
  assign ext_rise  = sync_r[3] & ~ext_d_r;
  assign hs_rise   = hs_act & ~hs_act_d_r;
  assign thr       = {cfg_r.phase_code, 11'h000};   // 11.25 deg per step
  assign d_old     = acc_r - thr;
  assign sum_pix   = {1'b0, acc_r} + {1'b0, step_r};
  assign sum_smp   = {1'b0, d_old} + {1'b0, step_r};
  assign ext_at    = {1'b0, ecyc_r, 5'h00};                           // elapsed cycles x 32
  assign ext_nx    = ext_at + 14'h0020;
  assign ext_goal  = {6'h00, eper_r} * {9'h000, cfg_r.phase_code}; // period x phase

  // external period measurement, counter saturates while no edge comes
  always_comb begin
    ecyc_nxt = ext_rise ? 8'h00 : ((ecyc_r == 8'hFF) ? 8'hFF : ecyc_r + 8'h01);
    eper_nxt = ext_rise ? ecyc_r + 8'h01 : eper_r;
  end

  // pixel and sampling ticks, internal or external source
  always_comb begin
    if (ext_sel) begin
      pix     = ext_rise;
      acc_nxt = ext_rise ? 16'h0000 : sum_pix[15:0];
      smp     = (cfg_r.phase_code == 5'h00) ? ext_rise : (ext_at < ext_goal && ext_nx >= ext_goal);
    end else begin
      pix     = sum_pix[16];
      acc_nxt = sum_pix[15:0];
      smp     = sum_smp[16]; // threshold crossing delays the sample
    end
  end

  // feedback divider counting divisor plus one pixel ticks
  // wraps at or above the divisor so a lowered divisor never runs off to the top
  always_comb begin
    div_tick = pix && (cnt_r >= div_r);
    cnt_nxt  = cnt_r;
    if (pix) cnt_nxt = div_tick ? 12'h000 : cnt_r + 12'h001;
  end

  // bang-bang frequency correction, gain set by pump current
  always_comb begin
    step_nxt = step_r;
    if (hs_rise && !freewheel_hold_in_act && cnt_r != 12'h000) begin
      if (cnt_r <= {1'b0, div_r[11:1]}) begin
        step_nxt = (step_r > {5'h00, pump_ua} + HSPLL_STEP_MIN) ?
                   step_r - {5'h00, pump_ua} : HSPLL_STEP_MIN;
      end else begin
        step_nxt = (step_r < 16'hFFFF - {5'h00, pump_ua}) ?
                   step_r + {5'h00, pump_ua} : 16'hFFFF;
      end
    end
  end

  // sync output retimed to the shifted sampling tick
  always_comb begin
    hso_nxt = smp ? hs_act : hso_r;
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      acc_r      <= 16'h0000;
      step_r     <= HSPLL_STEP_RST;
      cnt_r      <= 12'h000;
      hs_act_d_r <= 1'b1; // synced pin reads active after reset, no false edge
      hso_r      <= 1'b0;
      pix_r      <= 1'b0;
      smp_r      <= 1'b0;
      div_r_tick <= 1'b0;
      ecyc_r     <= 8'hFF;
      eper_r     <= 8'h00;
    end else begin
      acc_r      <= acc_nxt;
      step_r     <= step_nxt;
      cnt_r      <= cnt_nxt;
      hs_act_d_r <= hs_act;
      hso_r      <= hso_nxt;
      pix_r      <= pix;
      smp_r      <= smp;
      div_r_tick <= div_tick;
      ecyc_r     <= ecyc_nxt;
      eper_r     <= eper_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign REG_RDATA             = rdata_r;
  assign PIX_TICK              = pix_r;
  assign SAMPLE_TICK           = smp_r;
  assign DIV_TICK              = div_r_tick;
  assign ALIGNED_LINE_SYNC_OUT = hso_r;
  assign OSC_REGION_CODE       = cfg_r.osc_region_code;
  assign OSC_REGION_MIN_MHZ    = region_mhz;
  assign PUMP_UA               = pump_ua;
  assign OSC_STEP              = step_r;

  // ==========================================================
  // checks
  chk_freewheel_hold_in_holds_step: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    freewheel_hold_in_act |=> $stable(step_r)) else $error("step moved while coasting");
  chk_div_stage_only: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (REG_WE && REG_ADDR == HSPLL_OFS_DIV_UPPER) |=> $stable(div_r))
    else $error("divisor changed on upper byte write");
  chk_div_commit: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (REG_WE && REG_ADDR == HSPLL_OFS_DIV_LOWER) |=>
    div_r == {$past(div_upper_r), $past(REG_WDATA[7:4])}) else $error("divisor commit wrong");
  chk_div_ratio: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    div_tick |=> cnt_r == 12'h000 && DIV_TICK && PIX_TICK) else $error("divider wrap wrong");
  chk_region_bits: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (REG_WE && REG_ADDR == HSPLL_OFS_REGION) |=> OSC_REGION_CODE == $past(REG_WDATA[1:0]))
    else $error("region code not low two bits");
  chk_pump_map: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    cfg_r.pump_code == 3'h7 |-> PUMP_UA == HSPLL_IP7) else $error("pump decode wrong");
  chk_region_map: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    OSC_REGION_CODE == 2'h2 |-> OSC_REGION_MIN_MHZ == HSPLL_REG2_MHZ)
    else $error("region decode wrong");
  chk_sync_aligned: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    !smp |=> $stable(ALIGNED_LINE_SYNC_OUT)) else $error("sync out moved off sample");
  chk_ext_sample: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (ext_sel && cfg_r.phase_code == 5'h00 && ext_rise) |=> SAMPLE_TICK)
    else $error("external sample missing");
  chk_loop_moves: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    (hs_rise && !freewheel_hold_in_act && cnt_r > {1'b0, div_r[11:1]} && step_r < 16'hF000)
    |=> step_r > $past(step_r)) else $error("loop failed to speed up");
  cov_div_wrap:  cover property (@(posedge CLK_SYS) disable iff (!RESETN) div_tick);
  cov_freewheel_hold_in_hs:  cover property (@(posedge CLK_SYS) disable iff (!RESETN) hs_rise && freewheel_hold_in_act);
  cov_ext_shift: cover property (@(posedge CLK_SYS) disable iff (!RESETN) ext_sel && smp);

endmodule

// ==== tb/hspll_src.sv ====
// graphics source model: line sync and freewheel_hold_in pins of the far side
// assumes the bench clock; pins change just after its rising edge
module hspll_src
(
  input  wire logic clk,
  input  wire logic run,
  input  wire logic act_high,
  input  wire logic hold,
  input  wire logic freewheel_hold_in_high,
  output logic      hsync,
  output logic      freewheel_hold_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // line timing: 1000 clocks per line is a 25 kHz line rate
  localparam int LINE = 1000;
  int  cnt = 0;
  logic act;
  initial begin
    hsync = 1'b1;
    freewheel_hold_in = 1'b1;
  end
  // line counter, sync pulse of 40 clocks, pins at programmed levels
  always @(posedge clk) begin
    cnt <= (cnt == LINE - 1) ? 0 : cnt + 1;
    act = run && (cnt < 40);
    hsync <= act_high ? act : !act;
    freewheel_hold_in <= freewheel_hold_in_high ? hold : !hold;
  end
endmodule

// ==== tb/hspll_top_tb.sv ====
// self-checking bench for the line-locked pixel clock control block
// assumes hspll_pkg, hspll_top and the source model hspll_src compiled first
module hspll_top_tb
  import hspll_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_we = 1'b0;
  logic        ext_sel = 1'b0;
  logic        ext_pix = 1'b0;
  logic        run = 1'b0;
  logic        s_high = 1'b0;
  logic        s_hold = 1'b0;
  logic        s_chigh = 1'b0;
  logic        hsync, freewheel_hold_in, pix, smp, dtick, alo, alo_q, smp_q;
  logic [7:0]  rdata, min_mhz;
  logic [1:0]  region;
  logic [10:0] pump;
  logic [15:0] step, step_q;
  logic [11:0] d;
  logic [31:0] lfsr_r = 32'hAAC23C29;
  int          num_errors = 0;
  int          num_checks = 0;
  int          moves = 0, rises = 0, pcnt = 0, scnt = 0, ecnt = 0, n, m0, p0, s0;
  int          ahigh = 0, a0, pc = 0, lag = 0;
  int          pua[8] = '{50, 100, 150, 250, 350, 500, 750, 1500};
  int          mhz[4] = '{10, 45, 90, 150};
  // ==========================================================
  // clock, design and source
  initial forever #20 clk_sys = ~clk_sys;
  hspll_top hspll_top_i (.CLK_SYS(clk_sys), .RESETN(resetn), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WE(reg_we), .REG_RDATA(rdata), .HSYNC_IN(hsync),
    .FREEWHEEL_HOLD_IN(freewheel_hold_in), .EXT_CLK_SEL(ext_sel), .EXT_PIX_IN(ext_pix),
    .PIX_TICK(pix), .SAMPLE_TICK(smp), .DIV_TICK(dtick), .ALIGNED_LINE_SYNC_OUT(alo),
    .OSC_REGION_CODE(region), .OSC_REGION_MIN_MHZ(min_mhz), .PUMP_UA(pump),
    .OSC_STEP(step));
  hspll_src hspll_src_i (.clk(clk_sys), .run(run), .act_high(s_high), .hold(s_hold),
    .freewheel_hold_in_high(s_chigh), .hsync(hsync), .freewheel_hold_in(freewheel_hold_in));
  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_we <= 1'b1;
    @(posedge clk_sys);
    reg_we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    @(posedge clk_sys);
    reg_addr <= a;
    cyc(2);
    chk(nm, {8'h00, e}, {8'h00, rdata});
  endtask
  // pixels from one divider wrap to the next
  task automatic span(output int k);
    int w;
    k = 0;
    w = 0;
    cyc(0);
    while (dtick !== 1'b1 && w < 20000) begin
      cyc(1);
      w++;
    end
    cyc(1);
    while (dtick !== 1'b1 && w < 40000) begin
      k += (pix === 1'b1);
      cyc(1);
      w++;
    end
    k += (pix === 1'b1);
    if (w >= 40000) begin
      $display("wrong value divider wrap expected pulse seen none");
      num_errors++;
      conclude();
    end
  endtask
  // external pixel clock, 16 system clocks a period
  always @(posedge clk_sys) begin
    ecnt <= (ecnt + 1) % 16;
    if (ecnt == 0 || ecnt == 8) ext_pix <= ext_sel & ~ext_pix;
  end
  // per-cycle watch of ticks, aligned sync and loop step
  always @(posedge clk_sys) begin
    #1;
    if (resetn && alo !== alo_q) chk("sync on tick", 16'h1, {15'h0, smp | smp_q});
    rises += (alo === 1'b1 && alo_q === 1'b0);
    moves += (step !== step_q);
    pcnt += (pix === 1'b1);
    scnt += (smp === 1'b1);
    ahigh += (alo === 1'b1);
    pc = (pix === 1'b1) ? 0 : pc + 1;
    if (smp === 1'b1) lag = pc;
    alo_q = alo;
    smp_q = smp;
    step_q = step;
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(HSPLL_OFS_DIV_UPPER, 8'h35, "upper reset");
    rd(HSPLL_OFS_DIV_LOWER, 8'hF0, "lower reset");
    rd(8'hFF, 8'h00, "unmapped read");
    chk("step reset", HSPLL_STEP_RST, step);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      wr(HSPLL_OFS_PUMP, 8'(i));
      cyc(2);
      chk("pump current", 16'(pua[i]), {5'h00, pump});
    end
    for (int i = 0; i < 4; i++) begin
      lfsr_r = lfsr(lfsr_r);
      wr(HSPLL_OFS_REGION, {lfsr_r[5:0], 2'(i)});
      cyc(2);
      chk("region code", 16'(i), {14'h0, region});
      chk("region bound", 16'(mhz[i]), {8'h00, min_mhz});
    end
    $display("test decode done");
    span(n);
    chk("reset ratio", 16'h0360, 16'(n));
    lfsr_r = lfsr(lfsr_r);
    for (int j = 0; j < 2; j++) begin
      d = (j == 0) ? 12'(221 + lfsr_r[9:0] % 780) : 12'd221;
      m0 = (j == 0) ? 864 : n;
      wr(HSPLL_OFS_DIV_UPPER, d[11:4]);
      span(n);
      chk("ratio upper only", 16'(m0), 16'(n));
      wr(HSPLL_OFS_DIV_LOWER, {d[3:0], 4'h0});
      span(n);
      chk("ratio", 16'(d) + 16'h1, 16'(n));
    end
    $display("test divisor done");
    wr(HSPLL_OFS_REGION, 8'h00);
    wr(HSPLL_OFS_PUMP, 8'h02);
    run <= 1'b1;
    for (int p = 0; p < 4; p++) begin
      wr(HSPLL_OFS_POLARITY, 8'(p));
      s_high <= p[0];
      s_chigh <= p[1];
      s_hold <= 1'b0;
      cyc(10);
      m0 = moves;
      a0 = ahigh;
      cyc(2000);
      chk("loop corrects", 16'h1, {15'h0, moves > m0});
      chk("sync width", 16'h1, {15'h0, ahigh - a0 >= 20 && ahigh - a0 <= 200});
      s_hold <= 1'b1;
      cyc(10);
      m0 = moves;
      cyc(2000);
      chk("freewheel_hold_in holds", 16'(m0), 16'(moves));
    end
    chk("aligned sync seen", 16'h1, {15'h0, rises > 0});
    $display("test loop done");
    run <= 1'b0;
    s_hold <= 1'b0;
    @(posedge clk_sys);
    ext_sel <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      lfsr_r = lfsr(lfsr_r);
      d = (k == 0) ? 12'h000 : (k == 1) ? 12'h01F : {7'h00, lfsr_r[4:0]};
      wr(HSPLL_OFS_PHASE, d[7:0]);
      rd(HSPLL_OFS_PHASE, d[7:0], "phase code");
      p0 = pcnt;
      s0 = scnt;
      cyc(800);
      chk("ext pixels", 16'h1, {15'h0, pcnt - p0 >= 49 && pcnt - p0 <= 51});
      chk("sample per pixel", 16'h1, {15'h0, (scnt - s0) - (pcnt - p0) <= 1 &&
        (pcnt - p0) - (scnt - s0) <= 1});
      chk("sample lag", 16'(((int'(d[4:0]) + 1) / 2) % 16), 16'(lag));
    end
    $display("test phase done");
    conclude();
  end
endmodule
